// File: inc/srs_pkg.sv
`default_nettype none
package srs_pkg;
   // stretch after power-on or hard reset, in reference clock cycles
   localparam int STRETCH_CYCLES = 4096;
   // hard/soft pulse minimum at the pins, reference clock cycles
   localparam int MIN_PULSE_CYCLES = 4;
   // extra reference edges that keep the config word updating after release
   localparam int LOCK_DELAY_CYCLES = 2;
   // config word width
   localparam int CFG_WIDTH = 16;
   // reset value of the config word register
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // sequencer states
   typedef enum logic [1:0] {
      SRS_IDLE    = 2'b00, // running, no reset
      SRS_POR     = 2'b01, // power-on held or stretching
      SRS_HARD    = 2'b10, // hard reset stretching after a valid pulse, restarted if held again
      SRS_SOFT    = 2'b11  // soft reset pulse seen
   } srs_state_t;

   // pin triple for an open-drain reset line
   typedef struct packed {
      logic in;            // sampled pin level
      logic out;           // driven level (always low)
      logic oeN;           // low while driving
   } srs_pin_t;
endpackage
`default_nettype wire

// File: sim/srs_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module srs_board_model (
   input  wire logic        clk,           // reference clock
   input  wire logic        hardResetOeN,  // device pulls hard line
   input  wire logic        softResetOeN,  // device pulls soft line
   output var  logic        powerOnResetN, // power-on pin
   output wire logic        hardLine,      // resolved hard line
   output wire logic        softLine,      // resolved soft line
   output var  logic [15:0] cfgPins        // config straps
);
   logic hardPull; // board pulls hard low
   logic softPull; // board pulls soft low
   // pull-up wires: low while any party drives
   assign hardLine = ~(hardPull | ~hardResetOeN);
   assign softLine = ~(softPull | ~softResetOeN);
   // held low at power-up until supplies, osc, lock
   initial begin
      powerOnResetN = 1'b0;
      hardPull = 1'b0;
      softPull = 1'b0;
      cfgPins = 16'h0000;
   end
   // clean edges only, at falling clock, no glitch
   // bench holds pulses >= 4 cycles when valid
   task automatic setLine(input int which, input logic lvl);
      @(negedge clk);
      case (which)
         0: powerOnResetN = lvl;
         1: hardPull = ~lvl;
         default: softPull = ~lvl;
      endcase
   endtask
   // straps change only just before reset, except a refusal
   task automatic setCfg(input logic [15:0] v);
      @(negedge clk);
      cfgPins = v;
   endtask
endmodule
`default_nettype wire

// File: sim/tb_system_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_system_reset_sequencer;
   import srs_pkg::*;
   localparam int ST = 16; // shortened stretch
   logic        clk;       // reference clock
   logic        rst_n;     // block reset
   logic        porN;      // power-on pin
   logic        hardLine;  // hard wire level
   logic        softLine;  // soft wire level
   logic [15:0] cfgPins;   // straps
   logic        hOut;      // hard drive value
   logic        hOeN;      // hard enable
   logic        sOut;      // soft drive value
   logic        sOeN;      // soft enable
   logic [15:0] cfgWord;   // captured word
   logic        cfgLocked; // word frozen
   logic        iHard;     // internal hard reset
   logic        iSoft;     // internal soft reset
   int          err_count;  // mismatches
   int          num_checks; // comparisons
   int          cycles;     // timeout counter
   int          n;          // measured run
   logic [15:0] r;          // random strap word
   logic [15:0] cfgQ[$];    // straps seen in reset
   srs_reset_seq #(.STRETCH(ST)) DUT (.clk(clk), .rst_n(rst_n),
      .powerOnResetN(porN), .hardResetIn(hardLine), .hardResetOut(hOut),
      .hardResetOeN(hOeN), .softResetIn(softLine), .softResetOut(sOut),
      .softResetOeN(sOeN), .cfgPins(cfgPins), .cfgWord(cfgWord),
      .cfgLocked(cfgLocked), .intHardRstN(iHard), .intSoftRstN(iSoft));
   srs_board_model BRD (.clk(clk), .hardResetOeN(hOeN),
      .softResetOeN(sOeN), .powerOnResetN(porN), .hardLine(hardLine),
      .softLine(softLine), .cfgPins(cfgPins));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard, far above the expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         final_report();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits briefly for a low run, then counts its cycles
   task automatic lowRun(input int which, output int cnt);
      logic v;
      cnt = 0;
      for (int i = 0; i < 200; i++) begin
         @(negedge clk);
         v = (which == 0) ? hOeN : (which == 1) ? iHard : iSoft;
         if (v === 1'b0) cnt++;
         else if (cnt > 0 || i > 8) break;
      end
   endtask
   // expected run length; short pulses are refused
   function automatic int expRun(input int which, input int w);
      if (w < MIN_PULSE_CYCLES) return 0;
      return (which == 1) ? ST : 1;
   endfunction
   task automatic final_report();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      cycles = 0;
      void'($urandom(32'hab6e));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      // power-up: pin still held, all resets asserted
      repeat (3) @(negedge clk);
      check({hOeN, sOeN, iHard, iSoft, hOut, sOut}, 6'h00);
      BRD.setLine(0, 1'b1);
      lowRun(0, n);
      check(n, ST);
      check(sOeN, 1'b1);
      // later power-on pulse of random width
      BRD.setLine(0, 1'b0);
      repeat (1 + $urandom % 7) @(negedge clk);
      check({hOeN, sOeN, iHard, iSoft}, 4'h0);
      BRD.setLine(0, 1'b1);
      lowRun(0, n);
      check(n, ST);
      // hard and soft pulses at the width boundary
      for (int w = 3; w <= 4; w++) begin
         for (int which = 1; which <= 2; which++) begin
            BRD.setLine(which, 1'b0);
            repeat (w - 1) @(negedge clk);
            check({hOeN, hOut, sOut}, 3'h4);
            BRD.setLine(which, 1'b1);
            lowRun(which, n);
            check(n, expRun(which, w));
            repeat (4) @(negedge clk);
         end
      end
      // straps captured while hard reset held, then frozen
      r = 16'($urandom);
      BRD.setCfg(r);
      BRD.setLine(1, 1'b0);
      cfgQ.push_back(r);
      repeat (4) @(negedge clk);
      check(cfgWord, cfgQ[$]);
      check(cfgLocked, 1'b0);
      BRD.setLine(1, 1'b1);
      repeat (6) @(negedge clk);
      check(cfgLocked, 1'b1);
      BRD.setCfg(~r);
      repeat (4) @(negedge clk);
      check(cfgWord, cfgQ[$]);
      // stretch began 11 falling edges before this run is measured
      lowRun(1, n);
      check(n, ST - 11);
      final_report();
   end
endmodule
`default_nettype wire

// File: src/srs_cfg_latch.sv
`timescale 1ns/1ps
`default_nettype none
module srs_cfg_latch #(
   parameter int WIDTH = srs_pkg::CFG_WIDTH
) (
   input  wire logic             clk,        // reference clock
   input  wire logic             rst_n,      // async reset
   input  wire logic             resetHeld,  // hard or power-on active
   input  wire logic [WIDTH-1:0] cfgPins,    // config word pins
   output logic      [WIDTH-1:0] cfgWord,    // captured word
   output logic                  cfgLocked   // word frozen
);
   import srs_pkg::*;

   logic [WIDTH-1:0] cfg_reg, cfg_next;     // captured word
   logic [1:0]       lock_reg, lock_next;   // edges left after release

   ////////////////////////////////////////////////////////////////////////
   // capture while reset is held, then two more edges, then freeze
   always_comb begin
      cfg_next  = cfg_reg;
      lock_next = lock_reg;
      if (resetHeld) begin
         cfg_next  = cfgPins;
         lock_next = 2'(LOCK_DELAY_CYCLES);
      end else if (lock_reg != 2'h0) begin
         cfg_next  = cfgPins;
         lock_next = lock_reg - 2'h1;
      end
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg  <= CFG_RESET[WIDTH-1:0];
         lock_reg <= 2'(LOCK_DELAY_CYCLES);
      end else begin
         cfg_reg  <= cfg_next;
         lock_reg <= lock_next;
      end
   end

   assign cfgWord   = cfg_reg;
   assign cfgLocked = (lock_reg == 2'h0) && !resetHeld;

   ////////////////////////////////////////////////////////////////////////
   AST_CFG_FOLLOWS: assert property (
      @(posedge clk) disable iff (!rst_n)
      resetHeld |=> cfgWord == $past(cfgPins))
      else $error("config word not captured during reset");
   AST_CFG_FROZEN: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!resetHeld)[*3] |=> $stable(cfgWord))
      else $error("config word changed after lock");
endmodule
`default_nettype wire

// File: src/srs_reset_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - reset pins asynchronous, may assert anytime; pins are sampled here with no synchronizer
// - hold hard, soft low 4096 after power-on
// - internal resets stretched 4096 after hard release
// - capture config word each edge during reset
// - config word locks three edges after release
module srs_reset_seq #(
   parameter int STRETCH = srs_pkg::STRETCH_CYCLES, // stretch length
   parameter int MINW    = srs_pkg::MIN_PULSE_CYCLES, // valid pulse width
   parameter int WIDTH   = srs_pkg::CFG_WIDTH       // config word width
) (
   input  wire logic             clk,           // reference clock
   input  wire logic             rst_n,         // async reset
   input  wire logic             powerOnResetN, // power_on_reset_in pin
   input  wire logic             hardResetIn,   // hard_reset_line level
   output logic                  hardResetOut,  // hard line drive value
   output logic                  hardResetOeN,  // hard line enable, low=drive
   input  wire logic             softResetIn,   // soft_reset_line level
   output logic                  softResetOut,  // soft line drive value
   output logic                  softResetOeN,  // soft line enable, low=drive
   input  wire logic [WIDTH-1:0] cfgPins,       // config word pins
   output logic      [WIDTH-1:0] cfgWord,       // locked config word
   output logic                  cfgLocked,     // config word frozen
   output logic                  intHardRstN,   // internal hard reset
   output logic                  intSoftRstN    // internal soft reset
);
   import srs_pkg::*;

   localparam int CW = $clog2(STRETCH + 1);    // stretch counter width

   srs_state_t      state_reg, state_next;     // sequencer state
   logic [CW-1:0]   cnt_reg, cnt_next;         // stretch countdown
   logic [3:0]      hLow_reg, hLow_next;       // hard low run length
   logic [3:0]      sLow_reg, sLow_next;       // soft low run length
   logic            drvH_reg, drvH_next;       // driving hard line
   logic            drvS_reg, drvS_next;       // driving soft line
   logic            intH_reg, intH_next;       // internal hard, active low
   logic            intS_reg, intS_next;       // internal soft, active low
   logic [WIDTH-1:0] cfgW;                     // latch word
   logic            cfgL;                      // latch lock
   logic [WIDTH-1:0] cfg_reg;                  // word output flop
   logic            lck_reg;                   // lock output flop
   logic            resetHeld;                 // hard or power-on active

   // saturating run-length counter for pin low time
   function automatic logic [3:0] runLen(input logic low,
                                         input logic [3:0] n);
      if (!low)
         return 4'h0;
      else if (n == 4'hF)
         return n;
      else
         return n + 4'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pulse width tracking; pins are taken as already synchronous
   // own drive is masked, or every power-on stretch end would look like a pulse
   always_comb begin
      hLow_next = runLen(!hardResetIn && !drvH_reg, hLow_reg);
      sLow_next = runLen(!softResetIn && !drvS_reg, sLow_reg);
   end

   // sequencer: power-on beats hard beats soft
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         SRS_IDLE: begin
            // our own drive reads back low; ignore it by checking drv
            if (hLow_reg >= 4'(MINW) && hardResetIn) begin
               state_next = SRS_HARD;
               // this edge is already the first released cycle
               cnt_next   = CW'(STRETCH - 1);
            end else if (sLow_reg >= 4'(MINW) && softResetIn) begin
               state_next = SRS_SOFT;
            end
         end
         SRS_POR: begin
            if (cnt_reg != '0)
               cnt_next = cnt_reg - CW'(1);
            else
               state_next = SRS_IDLE;
         end
         SRS_HARD: begin
            if (!hardResetIn)
               cnt_next = CW'(STRETCH);  // restart while held again
            else if (cnt_reg != '0)
               cnt_next = cnt_reg - CW'(1);
            else
               state_next = SRS_IDLE;
         end
         SRS_SOFT: begin
            if (softResetIn)
               state_next = SRS_IDLE;
         end
      endcase
      // power-on wins at any time; a glitch here reaches logic unfiltered
      if (!powerOnResetN) begin
         state_next = SRS_POR;
         cnt_next   = CW'(STRETCH);
      end
   end

   // drive values derived from next state so outputs stay registered
   always_comb begin
      drvH_next = (state_next == SRS_POR);
      drvS_next = (state_next == SRS_POR);
      intH_next = !(state_next == SRS_POR || state_next == SRS_HARD);
      intS_next = intH_next && (state_next != SRS_SOFT);
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SRS_POR;
         cnt_reg   <= CW'(STRETCH);
         hLow_reg  <= 4'h0;
         sLow_reg  <= 4'h0;
         drvH_reg  <= 1'b1;
         drvS_reg  <= 1'b1;
         intH_reg  <= 1'b0;
         intS_reg  <= 1'b0;
         cfg_reg   <= CFG_RESET[WIDTH-1:0];
         lck_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         hLow_reg  <= hLow_next;
         sLow_reg  <= sLow_next;
         drvH_reg  <= drvH_next;
         drvS_reg  <= drvS_next;
         intH_reg  <= intH_next;
         intS_reg  <= intS_next;
         cfg_reg   <= cfgW;
         lck_reg   <= cfgL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // open-drain: value is always low, only the enable moves
   assign hardResetOut = 1'b0;
   assign softResetOut = 1'b0;
   assign hardResetOeN = !drvH_reg;
   assign softResetOeN = !drvS_reg;
   assign intHardRstN  = intH_reg;
   assign intSoftRstN  = intS_reg;
   assign cfgWord      = cfg_reg;
   assign cfgLocked    = lck_reg;

   // hard reset seen on the line, including our own drive
   assign resetHeld = !powerOnResetN || !hardResetIn;

   srs_cfg_latch #(
      .WIDTH     (WIDTH)
   ) u_cfg (
      .clk       (clk),
      .rst_n     (rst_n),
      .resetHeld (resetHeld),
      .cfgPins   (cfgPins),
      .cfgWord   (cfgW),
      .cfgLocked (cfgL)
   );

   ////////////////////////////////////////////////////////////////////////
   sequence porRelease;
      $rose(powerOnResetN);
   endsequence

   AST_POR_DRIVES: assert property (
      @(posedge clk) disable iff (!rst_n)
      !powerOnResetN |=> !hardResetOeN && !softResetOeN && !intHardRstN)
      else $error("power-on did not assert resets");
   AST_POR_STRETCH: assert property (
      @(posedge clk) disable iff (!rst_n)
      porRelease ##0 (powerOnResetN)[*8] |=> !hardResetOeN)
      else $error("hard line released early");
   AST_DRIVE_LOW: assert property (
      @(posedge clk) disable iff (!rst_n)
      !hardResetOeN || !softResetOeN |-> !hardResetOut && !softResetOut)
      else $error("reset line driven high");
   AST_HARD_INT: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_reg == SRS_HARD |-> !intHardRstN)
      else $error("internal reset inactive during stretch");
   AST_HARD_ENTRY: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_reg == SRS_IDLE && powerOnResetN && hardResetIn
      && hLow_reg >= 4'(MINW) |=> !intHardRstN)
      else $error("valid hard pulse ignored");
   AST_STRETCH_DONE: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_reg == SRS_HARD && cnt_reg == '0 && hardResetIn
      && powerOnResetN |=> state_reg == SRS_IDLE)
      else $error("stretch did not end");
   AST_SOFT_VALID: assert property (
      @(posedge clk) disable iff (!rst_n)
      state_reg == SRS_IDLE && powerOnResetN && hardResetIn && softResetIn
      && hLow_reg < 4'(MINW) && sLow_reg >= 4'(MINW) |=> !intSoftRstN)
      else $error("valid soft pulse ignored");
   AST_ASYNC_POR: assert property (
      @(posedge clk) disable iff (!rst_n)
      !powerOnResetN |=> state_reg == SRS_POR)
      else $error("power-on not taken");
   AST_CFG_CAPT: assert property (
      @(posedge clk) disable iff (!rst_n)
      resetHeld |=> ##1 cfgWord == $past(cfgPins, 2))
      else $error("config word not captured");
endmodule
`default_nettype wire
